// File: hw/cpu_sideband_control.v
// Purpose: Processor sideband control: A20 mask, init pulse, coprocessor
//          error handshake, NMI routing, stop-clock and sleep sequencing.
// Assumes: One core clock; software port writes arrive as one-cycle
//          strobes with data from logic on the same clock.
// Notes:   Processor outputs are open-drain: an _oe high pulls the pin low.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_sideband_consts.vh"

module cpu_sideband_control #(
  parameter INIT_CLKS  = `INIT_PULSE_CLKS,
  parameter SLEEP_CLKS = `SLEEP_DELAY_CLKS,
  parameter HOLD_CLKS  = `STRAP_HOLD_CLKS
) (
  // Clocking
  input  wire       i_core_clk,
  input  wire       i_reset,
  input  wire       i_clk_en,
  // Software port writes
  input  wire       i_fcp_wr,
  input  wire [7:0] i_fcp_wdata,
  input  wire       i_rcp_wr,
  input  wire [7:0] i_rcp_wdata,
  input  wire       i_fp_clear_wr,
  // Configuration bits
  input  wire       i_fp_error_enable,
  input  wire       i_nmi_to_acpi_route,
  input  wire       i_sleep_assert_enable,
  input  wire       i_selftest_enable_bit,
  input  wire [3:0] i_freq_select_field,
  // Events from bus and power logic
  input  wire       i_shutdown_cycle,
  input  wire       i_stop_grant_ack,
  input  wire       i_s1_enter,
  input  wire       i_deep_sleep_req,
  input  wire       i_wake,
  input  wire       i_system_error_n_internal,
  input  wire       i_system_error_n_host_msg,
  input  wire       i_io_check_serial_irq_stream,
  input  wire       i_cpu_reset_active,
  // Pins from outside
  input  wire       i_gate_a20_in,
  input  wire       i_kbc_reset_in_n,
  input  wire       i_fp_error_n,
  input  wire       i_system_error_n,
  // Processor pins, open drain
  output wire       o_addr20_mask_oe,
  output wire       o_init_oe,
  output wire       o_ignore_numeric_err_oe,
  output wire       o_stop_clock_oe,
  output wire       o_proc_sleep_oe,
  output wire       o_nmi_oe,
  output wire       o_cpu_int_request_oe,
  // Status and internal requests
  output reg  [7:0] o_fcp_image,
  output reg  [7:0] o_rcp_image,
  output reg        o_fp_irq_line,
  output reg        o_nmi,
  output reg        o_sci,
  output reg        o_deep_sleep_ready,
  output reg        o_selftest_init
);
  localparam ST_RUN   = 2'd0;
  localparam ST_STOP  = 2'd1;
  localparam ST_WAIT  = 2'd2;
  localparam ST_SLEEP = 2'd3;

  wire gate_a20_s;
  wire kbc_reset_s;
  wire fp_error_s;
  wire system_error_n_pin_s;
  wire init_busy;
  wire sleep_last;
  wire init_trigger;
  wire fcp_init_rise;
  wire rcp_sys_rise;
  wire system_error_n_any;

  reg        kbc_armed_reg;
  reg        init_pending_reg;
  reg        ignore_numeric_err_n_reg;
  reg        system_error_n_prev_reg;
  reg        io_check_n_prev_reg;
  reg  [1:0] pm_state_reg;
  reg  [1:0] pm_state_next;
  reg        deep_reg;
  reg        strap_active_reg;
  reg  [3:0] strap_val_reg;
  reg  [7:0] hold_cnt_reg;
  reg        stop_clock_reg;
  reg        sleep_reg;

  sync_edge #(.RESET_VAL(1'b1)) u_sync_a20 (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clk_en   (i_clk_en),
    .i_async    (i_gate_a20_in),
    .o_sync     (gate_a20_s)
  );

  sync_edge #(.RESET_VAL(1'b1)) u_sync_kbc (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clk_en   (i_clk_en),
    .i_async    (i_kbc_reset_in_n),
    .o_sync     (kbc_reset_s)
  );

  sync_edge #(.RESET_VAL(1'b1)) u_sync_fp_error_n (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clk_en   (i_clk_en),
    .i_async    (i_fp_error_n),
    .o_sync     (fp_error_s)
  );

  sync_edge #(.RESET_VAL(1'b1)) u_sync_system_error_n (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clk_en   (i_clk_en),
    .i_async    (i_system_error_n),
    .o_sync     (system_error_n_pin_s)
  );

  // Init trigger sources.
  assign fcp_init_rise = i_fcp_wr && i_fcp_wdata[`FCP_INIT_BIT] &&
                         !o_fcp_image[`FCP_INIT_BIT];
  // A write that also sets reset-cpu asks for a full reset, not for init.
  assign rcp_sys_rise  = i_rcp_wr && i_rcp_wdata[`RCP_SYS_RESET_BIT] &&
                         !i_rcp_wdata[`RCP_RESET_CPU_BIT] &&
                         !o_rcp_image[`RCP_SYS_RESET_BIT] &&
                         !o_rcp_image[`RCP_RESET_CPU_BIT];
  assign init_trigger  = i_shutdown_cycle || fcp_init_rise || rcp_sys_rise ||
                         (kbc_armed_reg && !kbc_reset_s);

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_fcp_image      <= 8'h00;
      o_rcp_image      <= 8'h00;
      kbc_armed_reg    <= 1'b1;
      init_pending_reg <= 1'b0;
      o_selftest_init  <= 1'b0;
    end else if (i_clk_en) begin
      if (i_fcp_wr) begin
        o_fcp_image <= i_fcp_wdata;
      end
      if (i_rcp_wr) begin
        o_rcp_image <= i_rcp_wdata;
      end
      o_selftest_init <= rcp_sys_rise && i_selftest_enable_bit;
      if (!kbc_reset_s) begin
        kbc_armed_reg <= 1'b0;
      end else begin
        kbc_armed_reg <= 1'b1;
      end
      // A trigger seen while stop-clock holds the pulse off waits here.
      if (init_trigger && stop_clock_reg) begin
        init_pending_reg <= 1'b1;
      end else if (!stop_clock_reg) begin
        init_pending_reg <= 1'b0;
      end
    end
  end

  pulse_counter #(.WIDTH(5)) u_init_cnt (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clk_en   (i_clk_en),
    .i_load     ((init_trigger || init_pending_reg) && !init_busy),
    .i_load_val (INIT_CLKS[4:0]),
    .i_freeze   (stop_clock_reg),
    .o_busy     (init_busy),
    .o_last     ()
  );
  // Load beats freeze, so a trigger under stop-clock is captured at once
  // and the whole pulse width waits until stop-clock falls.

  // Coprocessor error handshake.
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_fp_irq_line <= 1'b0;
      ignore_numeric_err_n_reg     <= 1'b0;
    end else if (i_clk_en) begin
      if (!i_fp_error_enable || fp_error_s) begin
        o_fp_irq_line <= 1'b0;
      end else if (i_fp_clear_wr) begin
        o_fp_irq_line <= 1'b0;
      end else begin
        o_fp_irq_line <= 1'b1;
      end
      if (fp_error_s) begin
        ignore_numeric_err_n_reg <= 1'b0;
      end else if (i_fp_clear_wr && i_fp_error_enable) begin
        ignore_numeric_err_n_reg <= 1'b1;
      end
    end
  end

  // NMI routing on rising edges of error sources.
  assign system_error_n_any = i_system_error_n_internal || i_system_error_n_host_msg || !system_error_n_pin_s;

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      system_error_n_prev_reg  <= 1'b0;
      io_check_n_prev_reg <= 1'b0;
      o_nmi          <= 1'b0;
      o_sci          <= 1'b0;
    end else if (i_clk_en) begin
      system_error_n_prev_reg  <= system_error_n_any;
      io_check_n_prev_reg <= i_io_check_serial_irq_stream;
      o_nmi <= ((system_error_n_any && !system_error_n_prev_reg) ||
                (i_io_check_serial_irq_stream && !io_check_n_prev_reg)) &&
               !i_nmi_to_acpi_route;
      o_sci <= ((system_error_n_any && !system_error_n_prev_reg) ||
                (i_io_check_serial_irq_stream && !io_check_n_prev_reg)) &&
               i_nmi_to_acpi_route;
    end
  end

  // Stop-clock and sleep sequencing.
  pulse_counter #(.WIDTH(4)) u_sleep_cnt (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clk_en   (i_clk_en),
    .i_load     (pm_state_reg == ST_STOP && i_stop_grant_ack),
    .i_load_val (SLEEP_CLKS[3:0]),
    .i_freeze   (1'b0),
    .o_busy     (),
    .o_last     (sleep_last)
  );

  always @* begin
    pm_state_next = pm_state_reg;
    case (pm_state_reg)
      ST_RUN: begin
        if (i_s1_enter || i_deep_sleep_req) begin
          pm_state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        if (i_wake) begin
          pm_state_next = ST_RUN;
        end else if (i_stop_grant_ack) begin
          pm_state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (i_wake) begin
          pm_state_next = ST_RUN;
        end else if (sleep_last) begin
          pm_state_next = ST_SLEEP;
        end
      end
      default: begin
        if (i_wake) begin
          pm_state_next = ST_RUN;
        end
      end
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      pm_state_reg       <= ST_RUN;
      deep_reg           <= 1'b0;
      stop_clock_reg     <= 1'b0;
      sleep_reg          <= 1'b0;
      o_deep_sleep_ready <= 1'b0;
    end else if (i_clk_en) begin
      pm_state_reg   <= pm_state_next;
      stop_clock_reg <= (pm_state_next != ST_RUN);
      // Sleep only when enabled, or always on the way to a deeper state.
      sleep_reg <= (pm_state_next == ST_SLEEP) &&
                   (i_sleep_assert_enable || deep_reg);
      // A deeper request may come while already stopped; it still forces
      // sleep so that the processors are parked before power goes.
      if (i_deep_sleep_req) begin
        deep_reg <= 1'b1;
      end else if (pm_state_next == ST_RUN) begin
        deep_reg <= 1'b0;
      end
      o_deep_sleep_ready <= deep_reg && pm_state_reg == ST_SLEEP;
    end
  end

  // Frequency straps while processor reset is active and just after.
  // The hold count rounds the hold time up to whole clocks.
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      strap_active_reg <= 1'b1;
      strap_val_reg    <= `FREQ_FIELD_RESET;
      hold_cnt_reg     <= 8'h00;
    end else if (i_clk_en) begin
      if (i_cpu_reset_active) begin
        strap_active_reg <= 1'b1;
        strap_val_reg    <= i_freq_select_field;
        hold_cnt_reg     <= HOLD_CLKS[7:0];
      end else if (hold_cnt_reg != 8'h00) begin
        hold_cnt_reg <= hold_cnt_reg - 8'h01;
      end else begin
        strap_active_reg <= 1'b0;
      end
    end
  end

  // A strap bit of one releases the pin; zero drives it low.
  assign o_addr20_mask_oe = strap_active_reg ?
      !strap_val_reg[`FREQ_A20_BIT] :
      (!o_fcp_image[`FCP_GATE_A20_BIT] && !gate_a20_s);
  assign o_ignore_numeric_err_oe = strap_active_reg ?
      !strap_val_reg[`FREQ_IGNORE_NUMERIC_ERR_N_BIT] : ignore_numeric_err_n_reg;
  assign o_nmi_oe = strap_active_reg && !strap_val_reg[`FREQ_NMI_BIT];
  assign o_cpu_int_request_oe = strap_active_reg &&
      !strap_val_reg[`FREQ_CPU_INT_REQUEST_BIT];
  assign o_init_oe       = init_busy && !stop_clock_reg;
  assign o_stop_clock_oe = stop_clock_reg;
  assign o_proc_sleep_oe = sleep_reg;
endmodule
`default_nettype wire

// File: hw/cpu_sideband_consts.vh
// Purpose: Shared constants for the processor sideband control block.
// Assumes: Core clock of 100 MHz, period 10 ns.
// Notes:   FCP and RCP bit positions refer to the software-visible port images; FREQ ones to the strap field.
`ifndef CPU_SIDEBAND_CONSTS_VH
`define CPU_SIDEBAND_CONSTS_VH

`define FCP_GATE_A20_BIT    1
`define FCP_INIT_BIT        0
`define RCP_RESET_CPU_BIT   2
`define RCP_SYS_RESET_BIT   1
`define FREQ_NMI_BIT        3
`define FREQ_CPU_INT_REQUEST_BIT       2
`define FREQ_IGNORE_NUMERIC_ERR_N_BIT      1
`define FREQ_A20_BIT        0
`define FREQ_FIELD_RESET    4'hf
`define CLK_PERIOD_NS       10
`define INIT_PULSE_CLKS     16
`define SLEEP_DELAY_CLKS    8
`define STRAP_HOLD_NS       120
`define STRAP_HOLD_CLKS     ((`STRAP_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: hw/sync_edge.v
// Purpose: Two-stage synchroniser for an outside level.
// Assumes: Input is asynchronous to i_core_clk.
// Notes:   Only the second stage is visible to other logic.
`timescale 1ns/1ps
`default_nettype none
module sync_edge #(
  parameter RESET_VAL = 1'b1
) (
  // Clocking
  input  wire i_core_clk,
  input  wire i_reset,
  input  wire i_clk_en,
  // Data
  input  wire i_async,
  output wire o_sync
);
  reg stage1_reg;
  reg stage2_reg;

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
    end else if (i_clk_en) begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
    end
  end

  assign o_sync = stage2_reg;
endmodule
`default_nettype wire

// File: hw/pulse_counter.v
// Purpose: Loadable down counter that reports when it is running.
// Assumes: Load has priority over counting.
// Notes:   A freeze input holds the count without losing it.
`timescale 1ns/1ps
`default_nettype none
module pulse_counter #(
  parameter WIDTH = 5
) (
  // Clocking
  input  wire             i_core_clk,
  input  wire             i_reset,
  input  wire             i_clk_en,
  // Control
  input  wire             i_load,
  input  wire [WIDTH-1:0] i_load_val,
  input  wire             i_freeze,
  // Status
  output wire             o_busy,
  output wire             o_last
);
  reg [WIDTH-1:0] count_reg;

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (i_clk_en) begin
      if (i_load) begin
        count_reg <= i_load_val;
      end else if (!i_freeze && count_reg != {WIDTH{1'b0}}) begin
        count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  assign o_busy = (count_reg != {WIDTH{1'b0}});
  assign o_last = (count_reg == {{(WIDTH-1){1'b0}}, 1'b1}) && !i_freeze;
endmodule
`default_nettype wire

// File: tb/cpu_sideband_checker_assertions.sv
// Purpose: Port-level checks for the processor sideband control block.
// Assumes: Straps are over 15 clocks after processor reset ends.
// Notes:   Init width checks pause while stop-clock is driven.
`timescale 1ns/1ps
`default_nettype none
module cpu_sideband_checker (
  input wire logic       i_core_clk, i_reset, i_fcp_wr, i_rcp_wr,
  input wire logic [7:0] i_fcp_wdata, i_rcp_wdata, o_fcp_image, o_rcp_image,
  input wire logic       i_fp_clear_wr, i_fp_error_enable, i_fp_error_n,
  input wire logic       i_nmi_to_acpi_route, i_sleep_assert_enable,
  input wire logic       i_stop_grant_ack, i_cpu_reset_active,
  input wire logic       i_system_error_n_internal, i_system_error_n_host_msg, i_io_check_serial_irq_stream,
  input wire logic [3:0] i_freq_select_field,
  input wire logic       i_gate_a20_in, o_addr20_mask_oe, o_init_oe,
  input wire logic       o_ignore_numeric_err_oe, o_stop_clock_oe,
  input wire logic       o_proc_sleep_oe, o_nmi_oe, o_cpu_int_request_oe,
  input wire logic       o_fp_irq_line, o_nmi, o_sci
);
  logic [3:0] cnt_reg;
  logic       ack_reg;
  wire        norm = cnt_reg == 4'hf;
  // Strap drive overrides the pins, so pin checks wait until it is over.
  always_ff @(posedge i_core_clk)
    if (i_reset || i_cpu_reset_active) cnt_reg <= 4'h0;
    else if (!norm) cnt_reg <= cnt_reg + 4'h1;
  always_ff @(posedge i_core_clk)
    if (i_reset || !o_stop_clock_oe) ack_reg <= 1'b0;
    else if (i_stop_grant_ack) ack_reg <= 1'b1;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_init16;
    o_init_oe[*8] ##1 o_init_oe[*8] ##1 !o_init_oe;
  endsequence
  sequence s_sleep_wait;
    !o_proc_sleep_oe[*8] ##1 o_proc_sleep_oe;
  endsequence
  a_init_width: assert property (disable iff (i_reset || o_stop_clock_oe)
    $rose(o_init_oe) |-> s_init16) else $error("init width wrong");
  a_fcp_init_trig: assert property (i_fcp_wr && i_fcp_wdata[0]
    && !o_fcp_image[0] && !o_init_oe && !o_stop_clock_oe |=> o_init_oe)
    else $error("fast port init missing");
  a_rcp_init_trig: assert property (i_rcp_wr && i_rcp_wdata[1]
    && !i_rcp_wdata[2] && !o_rcp_image[2] && !o_rcp_image[1] && !o_init_oe
    && !o_stop_clock_oe |=> o_init_oe) else $error("reset port init missing");
  a_init_frozen: assert property (o_stop_clock_oe |-> !o_init_oe)
    else $error("init during stop-clock");
  a_a20_mask_low: assert property ((!i_gate_a20_in)[*3]
    ##0 (norm && !o_fcp_image[1]) |-> o_addr20_mask_oe)
    else $error("a20 mask not driven");
  a_fp_irq_raise: assert property ((i_fp_error_enable
    && !i_fp_error_n && !i_fp_clear_wr)[*4] |=> o_fp_irq_line)
    else $error("fp_irq_line missing");
  a_ignore_numeric_err_n_on_clear: assert property (norm && i_fp_clear_wr
    && i_fp_error_enable && o_fp_irq_line
    |=> !o_fp_irq_line && o_ignore_numeric_err_oe) else $error("clear failed");
  a_ignore_numeric_err_n_needs_err: assert property (i_fp_error_n[*4] ##0 norm
    |-> !o_ignore_numeric_err_oe) else $error("ignore without error");
  a_fp_disabled: assert property (norm && !i_fp_error_enable
    && !o_ignore_numeric_err_oe |=> !o_fp_irq_line && !o_ignore_numeric_err_oe)
    else $error("disabled function active");
  a_nmi_routing: assert property ($rose(i_system_error_n_internal)
    || $rose(i_system_error_n_host_msg) || $rose(i_io_check_serial_irq_stream)
    |=> o_sci == $past(i_nmi_to_acpi_route) && o_nmi != o_sci)
    else $error("nmi routing wrong");
  a_sleep_delay: assert property (i_stop_grant_ack && o_stop_clock_oe
    && !ack_reg && i_sleep_assert_enable |=> s_sleep_wait)
    else $error("sleep delay wrong");
  a_strap_levels: assert property (i_cpu_reset_active[*2] |->
    {o_nmi_oe, o_cpu_int_request_oe, o_ignore_numeric_err_oe,
    o_addr20_mask_oe} == ~i_freq_select_field) else $error("strap wrong");
endmodule
bind cpu_sideband_control cpu_sideband_checker u_chk (.i_core_clk, .i_reset,
  .i_fcp_wr, .i_rcp_wr, .i_fcp_wdata, .i_rcp_wdata, .o_fcp_image, .o_rcp_image,
  .i_fp_clear_wr, .i_fp_error_enable, .i_fp_error_n, .i_nmi_to_acpi_route,
  .i_sleep_assert_enable, .i_stop_grant_ack, .i_cpu_reset_active,
  .i_system_error_n_internal, .i_system_error_n_host_msg, .i_io_check_serial_irq_stream, .i_freq_select_field,
  .i_gate_a20_in, .o_addr20_mask_oe, .o_init_oe, .o_ignore_numeric_err_oe,
  .o_stop_clock_oe, .o_proc_sleep_oe, .o_nmi_oe, .o_cpu_int_request_oe,
  .o_fp_irq_line, .o_nmi, .o_sci);
`default_nettype wire

// File: tb/cpu_pair_model.sv
// Purpose: Two processors answering stop-clock with stop-grant strobes.
// Assumes: Strobes change 1 ns after the rising edge.
// Notes:   The second processor answers one clock after the first.
`timescale 1ns/1ps
`default_nettype none
module cpu_pair_model (
  input  wire logic       i_core_clk,
  input  wire logic [3:0] i_delay,
  input  wire logic       i_stop_clock_oe,
  output var  logic       o_stop_grant_ack
);
  int cnt = 0;
  initial o_stop_grant_ack = 1'b0;
  always @(posedge i_core_clk) begin
    cnt = i_stop_clock_oe ? cnt + 1 : 0;
    o_stop_grant_ack <= #1 (cnt == i_delay || cnt == i_delay + 1);
  end
endmodule
`default_nettype wire

// File: tb/cpu_sideband_control_tb_top.sv
// Purpose: Self-checking bench for the processor sideband control block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Pulses are judged by counting over a window, so latency is free.
`timescale 1ns/1ps
`default_nettype none
module cpu_sideband_control_tb_top;
  logic clk = 0, rst = 1, fcp_wr = 0, rcp_wr = 0, clr_wr = 0, en = 0;
  logic route = 0, sleep_assert_enable = 0, st_en = 0, shut = 0, s1 = 0, deep = 0;
  logic wake = 0, se_i = 0, se_h = 0, ioc = 0, cpu_reset_n = 1, ga20 = 0;
  logic kbc_n = 1, fp_error_n_n = 1, system_error_n_n = 1;
  logic [7:0] fcp_d = 8'h00, rcp_d = 8'h00;
  logic [3:0] freq = 4'h5, dly = 4'h1;
  wire a20, init, ignore_numeric_err_n, stp, slp, nmi_p, cpu_int_request_p, irq, nmi, sci, dsr, sti, ack;
  wire [7:0] fcp_img, rcp_img;
  int fail_count = 0, comparisons = 0, n, m;
  cpu_sideband_control dut (.i_core_clk(clk), .i_reset(rst), .i_clk_en(1'b1),
    .i_fcp_wr(fcp_wr), .i_fcp_wdata(fcp_d), .i_rcp_wr(rcp_wr),
    .i_rcp_wdata(rcp_d), .i_fp_clear_wr(clr_wr), .i_fp_error_enable(en),
    .i_nmi_to_acpi_route(route), .i_sleep_assert_enable(sleep_assert_enable),
    .i_selftest_enable_bit(st_en), .i_freq_select_field(freq),
    .i_shutdown_cycle(shut), .i_stop_grant_ack(ack), .i_s1_enter(s1),
    .i_deep_sleep_req(deep), .i_wake(wake), .i_system_error_n_internal(se_i),
    .i_system_error_n_host_msg(se_h), .i_io_check_serial_irq_stream(ioc),
    .i_cpu_reset_active(cpu_reset_n), .i_gate_a20_in(ga20),
    .i_kbc_reset_in_n(kbc_n), .i_fp_error_n(fp_error_n_n),
    .i_system_error_n(system_error_n_n), .o_addr20_mask_oe(a20), .o_init_oe(init),
    .o_ignore_numeric_err_oe(ignore_numeric_err_n), .o_stop_clock_oe(stp),
    .o_proc_sleep_oe(slp), .o_nmi_oe(nmi_p), .o_cpu_int_request_oe(cpu_int_request_p),
    .o_fcp_image(fcp_img), .o_rcp_image(rcp_img), .o_fp_irq_line(irq),
    .o_nmi(nmi), .o_sci(sci), .o_deep_sleep_ready(dsr),
    .o_selftest_init(sti));
  cpu_pair_model cpus (.i_core_clk(clk), .i_delay(dly),
    .i_stop_clock_oe(stp), .o_stop_grant_ack(ack));
  always #5 clk = ~clk;
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int p, input logic [7:0] d);
    fcp_wr = (p == 0);
    rcp_wr = (p == 1);
    clr_wr = (p == 2);
    fcp_d = d;
    rcp_d = d;
    tick(1);
    {fcp_wr, rcp_wr, clr_wr} = 3'h0;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  // Counts high cycles of init/selftest (c 0) or nmi/sci (c 1).
  task automatic win(input int c, output int a, output int b);
    a = 0;
    b = 0;
    repeat (40) begin
      a += ((c ? nmi : init) === 1'b1);
      b += ((c ? sci : sti) === 1'b1);
      tick(1);
    end
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    tick(12);
    chk({nmi_p, cpu_int_request_p, ignore_numeric_err_n, a20}, 8'h00);
    rst = 0;
    tick(4);
    chk(fcp_img | rcp_img | init | stp | slp, 8'h00);
    cpu_reset_n = 0;
    tick(11);
    chk({nmi_p, cpu_int_request_p, ignore_numeric_err_n, a20}, {4'h0, ~freq});
    tick(4);
    for (int k = 0; k < 4; k++) begin
      wr(0, {6'h00, k[0], 1'b0});
      ga20 = k[1];
      tick(3);
      chk(a20, !(k[0] | k[1]));
    end
    wr(0, 8'h01);
    win(0, n, m);
    chk(n[7:0], 8'h10);
    wr(0, 8'h01);
    win(0, n, m);
    chk(n[7:0], 8'h00);
    st_en = 1;
    wr(1, 8'h02);
    win(0, n, m);
    chk(n[7:0], 8'h10);
    chk(m[7:0], 8'h01);
    wr(1, 8'h00);
    tick(1);
    wr(1, 8'h06);
    win(0, n, m);
    chk(n[7:0], 8'h00);
    st_en = 0;
    pulse(shut);
    win(0, n, m);
    chk(n[7:0], 8'h10);
    kbc_n = 0;
    win(0, n, m);
    chk(n[7:0], 8'h10);
    win(0, n, m);
    chk(n[7:0], 8'h00);
    kbc_n = 1;
    tick(4);
    kbc_n = 0;
    win(0, n, m);
    chk(n[7:0], 8'h10);
    kbc_n = 1;
    sleep_assert_enable = 1;
    pulse(s1);
    tick(1);
    chk(stp, 1);
    pulse(shut);
    win(0, n, m);
    chk({n[6:0], slp}, 8'h01);
    pulse(wake);
    win(0, n, m);
    chk({stp, slp, n[5:0]}, 8'h10);
    sleep_assert_enable = 0;
    dly = 4'h6;
    pulse(s1);
    tick(20);
    chk({stp, slp}, 8'h02);
    pulse(deep);
    tick(20);
    chk({stp, slp, dsr}, 8'h07);
    pulse(wake);
    en = 1;
    fp_error_n_n = 0;
    tick(5);
    chk({irq, ignore_numeric_err_n}, 8'h02);
    wr(2, 8'h00);
    chk({irq, ignore_numeric_err_n}, 8'h01);
    fp_error_n_n = 1;
    tick(5);
    chk({irq, ignore_numeric_err_n}, 8'h00);
    en = 0;
    fp_error_n_n = 0;
    tick(5);
    wr(2, 8'h00);
    chk({irq, ignore_numeric_err_n}, 8'h00);
    fp_error_n_n = 1;
    for (int k = 0; k < 8; k++) begin
      route = k[2];
      {se_i, se_h, ioc, system_error_n_n} = {k[1:0] == 2'h0, k[1:0] == 2'h1,
        k[1:0] == 2'h2, k[1:0] != 2'h3};
      win(1, n, m);
      chk({n[3:0], m[3:0]}, k[2] ? 8'h01 : 8'h10);
      {se_i, se_h, ioc, system_error_n_n} = 4'h1;
      tick(4);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
